// file: design/general_pin_one_mux.sv
// AXI4-Lite configured function multiplexer for general pin one.
`timescale 1ns/1ps

// Functional notes
// - Config bits 4:0 are the function code choosing the pin's signal.
// - Code 00000 drives the inverted power-on reset out.
// - Code 00001 drives high once the wake-up timer expired.
// - Code 00010 drives high while supply is below low-battery threshold.
// - Code 00011 is direct digital input; 01010 is direct digital output.
// - Codes 00100/00101/00110 are interrupt inputs: falling, rising, any edge.
// - Code 00111 routes the pin to the converter, no digital drive.
// - Code 01110 presents the internal reference voltage.
// - Code 01111 outputs the bit clock paired with serial data.
// - Code 10000 takes the transmit bit stream in for direct modulation.
// - Code 10001 takes an external retransmission request in.
// - Code 10010 shows transmit state; 10101 shows receive state.
// - Code 10011 shows transmit almost-full; 10110 receive almost-full.
// - Code 10100 drives the demodulated receive bit stream.
// - Codes 10111 and 11000 drive antenna switch one and two.
// - Code 11001 shows valid preamble; 11010 invalid preamble.
// - Code 11011 shows synchronisation word detected.
// - Code 11100 shows the clear channel assessment result.
// - Bit 5 enables the pull-up only while the pin is a digital input.
// - Bits 7:6 hold a read-write drive strength for the output.
module general_pin_one_mux
	import pin_mux_pkg::*;
#(
	parameter logic [CFG_W-1:0] CONFIG_RESET = CFG_RESET
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic por_active,
	input wire logic wakeup_timer_expired,
	input wire logic low_battery,
	input wire logic bit_clock,
	input wire logic tx_state,
	input wire logic tx_almost_full,
	input wire logic rx_data,
	input wire logic rx_state,
	input wire logic rx_almost_full,
	input wire logic antenna_one,
	input wire logic antenna_two,
	input wire logic preamble_valid,
	input wire logic preamble_invalid,
	input wire logic sync_word_found,
	input wire logic channel_clear,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_pullup_en,
	output logic [1:0] pin_drive_strength,
	output logic pin_adc_route,
	output logic pin_vref_route,
	output logic direct_in_value,
	output logic tx_mod_data,
	output logic retransmit_req,
	output logic ext_irq_flag,
	output logic ext_irq_event
);
	typedef enum {WR_IDLE, WR_RESP} wr_state_e;

	wr_state_e wr_state;
	wr_state_e next_wr_state;
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [DATA_W/8-1:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [DATA_W-1:0] next_w_data;
	logic [DATA_W/8-1:0] next_w_strb;
	logic [1:0] next_bresp;
	logic next_bvalid;
	logic next_awready;
	logic next_wready;

	logic [CFG_W-1:0] pin_one_config;
	logic [CFG_W-1:0] next_pin_one_config;
	logic direct_out_value;
	logic next_direct_out_value;
	logic irq_clear;

	logic [DATA_W-1:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_rvalid;
	logic next_arready;

	logic [4:0] pin_one_function_code;
	logic pin_one_pullup_enable;
	logic next_pin_out;
	logic next_pin_oe;
	logic next_pin_pullup_en;
	logic next_pin_adc_route;
	logic next_pin_vref_route;
	logic next_direct_in_value;
	logic next_tx_mod_data;
	logic next_retransmit_req;
	irq_mode_e irq_mode;

	pin_level_if lvl ();

	pin_input_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.pin_raw(pin_in),
		.lvl(lvl.source)
	);

	pin_edge_flag u_edge (
		.mclk(mclk),
		.srst(srst),
		.mode(irq_mode),
		.clear(irq_clear),
		.lvl(lvl.sink),
		.flag(ext_irq_flag),
		.event_pulse(ext_irq_event)
	);

	assign pin_one_function_code = pin_one_config[FUNC_MSB:FUNC_LSB];
	assign pin_one_pullup_enable = pin_one_config[PULLUP_BIT];
	assign pin_drive_strength = pin_one_config[DRIVE_MSB:DRIVE_LSB];

	// Write channel: address and data are taken in either order, then one response.
	always_comb begin
		next_wr_state = wr_state;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bresp = s_axi_bresp;
		next_bvalid = s_axi_bvalid;
		next_pin_one_config = pin_one_config;
		next_direct_out_value = direct_out_value;
		irq_clear = 1'b0;
		unique case (wr_state)
			WR_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					next_aw_held = 1'b1;
					next_aw_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					next_w_held = 1'b1;
					next_w_data = s_axi_wdata;
					next_w_strb = s_axi_wstrb;
				end
				if (aw_held && w_held) begin
					next_bresp = RESP_OKAY;
					if (aw_addr == CFG_OFFSET) begin
						if (w_strb[0]) begin
							next_pin_one_config = w_data[CFG_W-1:0];
						end
					end else if (aw_addr == STATUS_OFFSET) begin
						// Writing one clears the interrupt flag.
						irq_clear = w_strb[0] & w_data[STAT_IRQ_BIT];
					end else if (aw_addr == CTRL_OFFSET) begin
						if (w_strb[0]) begin
							next_direct_out_value = w_data[CTRL_OUT_BIT];
						end
					end else begin
						next_bresp = RESP_SLVERR;
					end
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_bvalid = 1'b1;
					next_wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_wr_state = WR_IDLE;
				end
			end
		endcase
		next_awready = (next_wr_state == WR_IDLE) && !next_aw_held;
		next_wready = (next_wr_state == WR_IDLE) && !next_w_held;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_state <= WR_IDLE;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			pin_one_config <= CONFIG_RESET;
			direct_out_value <= 1'b0;
		end else begin
			wr_state <= next_wr_state;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bresp <= next_bresp;
			s_axi_bvalid <= next_bvalid;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			pin_one_config <= next_pin_one_config;
			direct_out_value <= next_direct_out_value;
		end
	end

	// Read channel: one read at a time, data registered with the response.
	always_comb begin
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_rvalid = s_axi_rvalid;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			if (s_axi_araddr == CFG_OFFSET) begin
				next_rdata[CFG_W-1:0] = pin_one_config;
			end else if (s_axi_araddr == STATUS_OFFSET) begin
				next_rdata[STAT_IRQ_BIT] = ext_irq_flag;
				next_rdata[STAT_LEVEL_BIT] = lvl.level;
			end else if (s_axi_araddr == CTRL_OFFSET) begin
				next_rdata[CTRL_OUT_BIT] = direct_out_value;
			end else begin
				next_rresp = RESP_SLVERR;
			end
		end
		next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= next_arready;
		end
	end

	// Edge mode for the interrupt flag follows the function code.
	always_comb begin
		unique case (pin_one_function_code)
			FN_IRQ_FALL: irq_mode = IRQ_FALL;
			FN_IRQ_RISE: irq_mode = IRQ_RISE;
			FN_IRQ_ANY: irq_mode = IRQ_ANY;
			default: irq_mode = IRQ_OFF;
		endcase
	end

	// Pin multiplexer. Reserved test codes fall to the constant-low default, so a
	// stray test code cannot put anything unexpected on the pin.
	always_comb begin
		next_pin_out = 1'b0;
		next_pin_oe = 1'b1;
		next_pin_adc_route = 1'b0;
		next_pin_vref_route = 1'b0;
		next_direct_in_value = direct_in_value;
		next_tx_mod_data = tx_mod_data;
		next_retransmit_req = 1'b0;
		unique case (pin_one_function_code)
			FN_POR_INV: next_pin_out = ~por_active;
			FN_WAKEUP: next_pin_out = wakeup_timer_expired;
			FN_LOW_BATT: next_pin_out = low_battery;
			FN_DIRECT_IN: begin
				next_pin_oe = 1'b0;
				next_direct_in_value = lvl.level;
			end
			FN_IRQ_FALL, FN_IRQ_RISE, FN_IRQ_ANY: next_pin_oe = 1'b0;
			FN_ADC_IN: begin
				next_pin_oe = 1'b0;
				next_pin_adc_route = 1'b1;
			end
			FN_DIRECT_OUT: next_pin_out = direct_out_value;
			FN_VREF: begin
				next_pin_oe = 1'b0;
				next_pin_vref_route = 1'b1;
			end
			FN_BIT_CLK: next_pin_out = bit_clock;
			FN_TX_DATA_IN: begin
				next_pin_oe = 1'b0;
				next_tx_mod_data = lvl.level;
			end
			FN_RETX_REQ: begin
				next_pin_oe = 1'b0;
				next_retransmit_req = lvl.level;
			end
			FN_TX_STATE: next_pin_out = tx_state;
			FN_RX_STATE: next_pin_out = rx_state;
			FN_TX_ALMOST_FULL: next_pin_out = tx_almost_full;
			FN_RX_ALMOST_FULL: next_pin_out = rx_almost_full;
			FN_RX_DATA: next_pin_out = rx_data;
			FN_ANT1: next_pin_out = antenna_one;
			FN_ANT2: next_pin_out = antenna_two;
			FN_PRE_VALID: next_pin_out = preamble_valid;
			FN_PRE_INVALID: next_pin_out = preamble_invalid;
			FN_SYNC_WORD: next_pin_out = sync_word_found;
			FN_CCA: next_pin_out = channel_clear;
			FN_HIGH: next_pin_out = 1'b1;
			default: next_pin_out = 1'b0;
		endcase
		// The pull-up only acts on a digital input; on an output it would waste current.
		next_pin_pullup_en = pin_one_pullup_enable &&
			is_digital_input(pin_one_function_code);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			pin_pullup_en <= 1'b0;
			pin_adc_route <= 1'b0;
			pin_vref_route <= 1'b0;
			direct_in_value <= 1'b0;
			tx_mod_data <= 1'b0;
			retransmit_req <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			pin_pullup_en <= next_pin_pullup_en;
			pin_adc_route <= next_pin_adc_route;
			pin_vref_route <= next_pin_vref_route;
			direct_in_value <= next_direct_in_value;
			tx_mod_data <= next_tx_mod_data;
			retransmit_req <= next_retransmit_req;
		end
	end
endmodule : general_pin_one_mux

// file: design/pin_edge_flag.sv
// Sticky external interrupt flag raised by the selected pin edge.
`timescale 1ns/1ps
module pin_edge_flag
	import pin_mux_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input irq_mode_e mode,
	input wire logic clear,
	pin_level_if.sink lvl,
	output logic flag,
	output logic event_pulse
);
	logic hit;
	logic next_flag;
	logic next_event_pulse;

	always_comb begin
		unique case (mode)
			IRQ_FALL: hit = lvl.fall;
			IRQ_RISE: hit = lvl.rise;
			IRQ_ANY: hit = lvl.rise | lvl.fall;
			IRQ_OFF: hit = 1'b0;
		endcase
		// A new edge in the clearing cycle keeps the flag set.
		next_flag = hit | (flag & ~clear);
		next_event_pulse = hit;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			flag <= 1'b0;
			event_pulse <= 1'b0;
		end else begin
			flag <= next_flag;
			event_pulse <= next_event_pulse;
		end
	end
endmodule : pin_edge_flag

// file: design/pin_input_sync.sv
// Two-stage synchroniser for the pin input with edge detection on the settled level.
`timescale 1ns/1ps
module pin_input_sync (
	input wire logic mclk,
	input wire logic srst,
	input wire logic pin_raw,
	pin_level_if.source lvl
);
	logic meta;
	logic settled;
	logic settled_d;
	logic next_meta;
	logic next_settled;
	logic next_settled_d;

	always_comb begin
		next_meta = pin_raw;
		next_settled = meta;
		next_settled_d = settled;
	end

	// Edges compare the second and third stages, never the first.
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta <= 1'b0;
			settled <= 1'b0;
			settled_d <= 1'b0;
		end else begin
			meta <= next_meta;
			settled <= next_settled;
			settled_d <= next_settled_d;
		end
	end

	assign lvl.level = settled;
	assign lvl.rise = settled & ~settled_d;
	assign lvl.fall = ~settled & settled_d;
endmodule : pin_input_sync

// file: inc/pin_level_if.sv
// Synchronised pin level and its edges, passed from the synchroniser to its users.
`timescale 1ns/1ps
interface pin_level_if;
	logic level;
	logic rise;
	logic fall;
	modport source (output level, output rise, output fall);
	modport sink (input level, input rise, input fall);
endinterface : pin_level_if

// file: inc/pin_mux_pkg.sv
// Constants, field layout and function codes for the general pin one multiplexer.
package pin_mux_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CFG_W = 8;
	localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h0c;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h14;
	localparam int FUNC_LSB = 0;
	localparam int FUNC_MSB = 4;
	localparam int PULLUP_BIT = 5;
	localparam int DRIVE_LSB = 6;
	localparam int DRIVE_MSB = 7;
	localparam int STAT_IRQ_BIT = 0;
	localparam int STAT_LEVEL_BIT = 1;
	localparam int CTRL_OUT_BIT = 0;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [4:0] FN_POR_INV = 5'h00;
	localparam logic [4:0] FN_WAKEUP = 5'h01;
	localparam logic [4:0] FN_LOW_BATT = 5'h02;
	localparam logic [4:0] FN_DIRECT_IN = 5'h03;
	localparam logic [4:0] FN_IRQ_FALL = 5'h04;
	localparam logic [4:0] FN_IRQ_RISE = 5'h05;
	localparam logic [4:0] FN_IRQ_ANY = 5'h06;
	localparam logic [4:0] FN_ADC_IN = 5'h07;
	localparam logic [4:0] FN_DIRECT_OUT = 5'h0a;
	localparam logic [4:0] FN_VREF = 5'h0e;
	localparam logic [4:0] FN_BIT_CLK = 5'h0f;
	localparam logic [4:0] FN_TX_DATA_IN = 5'h10;
	localparam logic [4:0] FN_RETX_REQ = 5'h11;
	localparam logic [4:0] FN_TX_STATE = 5'h12;
	localparam logic [4:0] FN_TX_ALMOST_FULL = 5'h13;
	localparam logic [4:0] FN_RX_DATA = 5'h14;
	localparam logic [4:0] FN_RX_STATE = 5'h15;
	localparam logic [4:0] FN_RX_ALMOST_FULL = 5'h16;
	localparam logic [4:0] FN_ANT1 = 5'h17;
	localparam logic [4:0] FN_ANT2 = 5'h18;
	localparam logic [4:0] FN_PRE_VALID = 5'h19;
	localparam logic [4:0] FN_PRE_INVALID = 5'h1a;
	localparam logic [4:0] FN_SYNC_WORD = 5'h1b;
	localparam logic [4:0] FN_CCA = 5'h1c;
	localparam logic [4:0] FN_HIGH = 5'h1d;

	typedef enum logic [1:0] {IRQ_OFF, IRQ_FALL, IRQ_RISE, IRQ_ANY} irq_mode_e;

	// True for every code that takes the pin as a digital input.
	function automatic logic is_digital_input(input logic [4:0] code);
		is_digital_input = (code == FN_DIRECT_IN) || (code == FN_IRQ_FALL) ||
			(code == FN_IRQ_RISE) || (code == FN_IRQ_ANY) ||
			(code == FN_TX_DATA_IN) || (code == FN_RETX_REQ);
	endfunction : is_digital_input
endpackage : pin_mux_pkg

// file: verification/pin_mux_sva.sv
// Port assertions for the general pin one multiplexer.
`timescale 1ns/1ps
module pin_mux_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic s_axi_bvalid,
	input wire logic por_active,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pin_pullup_en,
	input wire logic [1:0] pin_drive_strength,
	input wire logic pin_adc_route,
	input wire logic pin_vref_route,
	input wire logic direct_in_value,
	input wire logic tx_mod_data,
	input wire logic retransmit_req,
	input wire logic ext_irq_flag,
	input wire logic ext_irq_event
);
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (srst);
	AST_POR_OUT: assert property ($fell(srst) |=> pin_oe && pin_out != $past(por_active))
		else $error("pin not inverted reset after release");
	AST_DIN: assert property ($changed(direct_in_value) |-> !pin_oe)
		else $error("direct input moved while pin driven");
	AST_IRQ_SET: assert property (ext_irq_event |-> !pin_oe ##[0:1] ext_irq_flag)
		else $error("edge event without flag");
	AST_IRQ_CAUSE: assert property ($rose(ext_irq_flag) |->
		ext_irq_event || $past(ext_irq_event))
		else $error("flag rose without edge event");
	AST_ADC: assert property (pin_adc_route |-> !pin_oe && !pin_pullup_en)
		else $error("converter route with digital drive");
	AST_VREF: assert property (pin_vref_route |-> !pin_oe && !pin_adc_route)
		else $error("reference route with digital drive");
	AST_TXD: assert property ($changed(tx_mod_data) |-> !pin_oe)
		else $error("modulation data moved while pin driven");
	AST_RETX: assert property (retransmit_req |-> !pin_oe)
		else $error("retransmit request while pin driven");
	AST_PULLUP: assert property (pin_pullup_en |-> !pin_oe)
		else $error("pull-up on a driven pin");
	AST_DRIVE: assert property ($changed(pin_drive_strength) |->
		##[0:1] s_axi_bvalid or $past(s_axi_bvalid))
		else $error("drive strength changed without a write");
endmodule : pin_mux_sva
bind general_pin_one_mux pin_mux_sva u_pin_mux_sva (.*);

// file: verification/pin_partner.sv
// Outside circuitry on general pin one: resolves the wire level.
`timescale 1ns/1ps
module pin_partner (
	input wire logic mclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pin_pullup_en,
	input wire logic ext_val,
	input wire logic ext_en,
	output logic pin_in
);
	logic wander = 1'b0;
	always @(posedge mclk) wander <= ~wander;
	// A floating pin toggles every cycle so that a stale level can never pass for a real one.
	always_comb begin
		if (pin_oe) pin_in = pin_out;
		else if (ext_en) pin_in = ext_val;
		else if (pin_pullup_en) pin_in = 1'b1;
		else pin_in = wander;
	end
endmodule : pin_partner

// file: verification/tb_general_pin_one_mux.sv
// Self-checking bench for the general pin one multiplexer.
`timescale 1ns/1ps
module tb_general_pin_one_mux
	import pin_mux_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [14:0] src = 15'h0;
	logic ext_val = 1'b0;
	logic ext_en = 1'b0;
	logic pin_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, pin_drive_strength;
	logic [31:0] s_axi_rdata;
	logic pin_out, pin_oe, pin_pullup_en, pin_adc_route, pin_vref_route;
	logic direct_in_value, tx_mod_data, retransmit_req, ext_irq_flag, ext_irq_event;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	// Entry i is the code that routes src[i]; the last one is the inverted reset output.
	// Scenarios keep to assigned codes; only t_const probes reserved ones on purpose.
	logic [4:0] oc [15] = '{5'h01, 5'h02, 5'h0f, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
		5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h00};

	general_pin_one_mux u_general_pin_one_mux (
		.wakeup_timer_expired(src[0]), .low_battery(src[1]), .bit_clock(src[2]),
		.tx_state(src[3]), .tx_almost_full(src[4]), .rx_data(src[5]), .rx_state(src[6]),
		.rx_almost_full(src[7]), .antenna_one(src[8]), .antenna_two(src[9]),
		.preamble_valid(src[10]), .preamble_invalid(src[11]), .sync_word_found(src[12]),
		.channel_clear(src[13]), .por_active(src[14]), .*);
	pin_partner u_pin_partner (.*);

	always #10 mclk = ~mclk;

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	task automatic chkb(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask : chkb

	task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chkw

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : wait_cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic set_code(input logic [7:0] v);
		logic [1:0] r;
		wr(CFG_OFFSET, {24'h0, v}, r);
		chkw({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : set_code

	task automatic t_reset();
		logic [1:0] r;
		logic [31:0] d;
		chkb(pin_oe, 1'b1);
		chkb(pin_out, !src[14]);
		rd(CFG_OFFSET, d, r);
		chkw(d, {24'h0, CFG_RESET});
		rd(8'h40, d, r);
		chkw({d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'hff, r);
		chkw({30'h0, r}, {30'h0, RESP_SLVERR});
	endtask : t_reset

	// Every other source is driven opposite, so a wrong selection shows at once.
	task automatic t_outputs();
		for (int i = 0; i < 15; i++) begin
			set_code({3'h0, oc[i]});
			src <= 15'h1 << i;
			wait_cyc(2);
			chkb(pin_oe, 1'b1);
			chkb(pin_out, i != 14);
			@(posedge mclk);
			src <= ~(15'h1 << i);
			wait_cyc(2);
			chkb(pin_out, i == 14);
		end
	endtask : t_outputs

	task automatic t_const();
		logic [4:0] cc [8] = '{5'h1d, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h1e, 5'h1f};
		logic [1:0] r;
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			set_code({3'h0, cc[i]});
			src <= 15'h7fff;
			wait_cyc(2);
			chkb(pin_out, i == 0);
		end
		set_code(8'h0a);
		wr(CTRL_OFFSET, 32'h1, r);
		rd(CTRL_OFFSET, d, r);
		chkw(d, 32'h1);
		wait_cyc(2);
		chkb(pin_out, 1'b1);
		wr(CTRL_OFFSET, 32'h0, r);
		wait_cyc(2);
		chkb(pin_out, 1'b0);
	endtask : t_const

	task automatic t_inputs();
		logic [4:0] ic [3] = '{5'h03, 5'h10, 5'h11};
		for (int i = 0; i < 3; i++) begin
			set_code({3'h1, ic[i]});
			ext_en <= 1'b1;
			ext_val <= 1'b1;
			wait_cyc(5);
			chkb(pin_oe, 1'b0);
			chkb(pin_pullup_en, 1'b1);
			chkw({29'h0, direct_in_value, tx_mod_data, retransmit_req}, 32'h4 >> i);
			@(posedge mclk);
			ext_val <= 1'b0;
			wait_cyc(5);
			chkw({29'h0, direct_in_value, tx_mod_data, retransmit_req}, 32'h0);
		end
		set_code(8'h23);
		ext_en <= 1'b0;
		wait_cyc(5);
		chkb(direct_in_value, 1'b1);
		set_code(8'h03);
		wait_cyc(2);
		chkb(pin_pullup_en, 1'b0);
	endtask : t_inputs

	task automatic t_irq();
		logic [1:0] r;
		logic [31:0] d;
		for (int m = 0; m < 3; m++) begin
			set_code(8'(4 + m));
			ext_en <= 1'b1;
			ext_val <= 1'b0;
			wait_cyc(5);
			wr(STATUS_OFFSET, 32'h1, r);
			wait_cyc(1);
			chkb(ext_irq_flag, 1'b0);
			@(posedge mclk);
			ext_val <= 1'b1;
			wait_cyc(3);
			chkb(ext_irq_event, m != 0);
			wait_cyc(3);
			chkb(ext_irq_flag, m != 0);
			rd(STATUS_OFFSET, d, r);
			chkb(d[STAT_IRQ_BIT], m != 0);
			chkb(d[STAT_LEVEL_BIT], 1'b1);
			wr(STATUS_OFFSET, 32'h1, r);
			ext_val <= 1'b0;
			wait_cyc(6);
			chkb(ext_irq_flag, m != 1);
		end
	endtask : t_irq

	task automatic t_analog();
		set_code(8'h27);
		wait_cyc(2);
		chkw({28'h0, pin_oe, pin_pullup_en, pin_adc_route, pin_vref_route}, 32'h2);
		set_code(8'h2e);
		wait_cyc(2);
		chkw({28'h0, pin_oe, pin_pullup_en, pin_adc_route, pin_vref_route}, 32'h1);
	endtask : t_analog

	task automatic t_drive();
		logic [1:0] r;
		logic [31:0] d;
		set_code(8'hdd);
		rd(CFG_OFFSET, d, r);
		chkw(d, 32'hdd);
		wait_cyc(2);
		chkw({30'h0, pin_drive_strength}, 32'h3);
		chkb(pin_out, 1'b1);
		// A write with byte lane 0 disabled must leave the register alone.
		@(posedge mclk);
		s_axi_wstrb <= 4'h0;
		wr(CFG_OFFSET, 32'h0, r);
		s_axi_wstrb <= 4'hf;
		rd(CFG_OFFSET, d, r);
		chkw(d, 32'hdd);
	endtask : t_drive

	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		wait_cyc(1);
		t_reset();
		t_outputs();
		t_const();
		t_inputs();
		t_irq();
		t_analog();
		t_drive();
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		wait_cyc(1);
		t_reset();
		finish_test();
	end
endmodule : tb_general_pin_one_mux
